/* bench/tb_usfc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_usfc_top;
   logic ref_clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, slow = 1'b0;
   logic ce = 1'b1;
   logic [3:0] pinsN = 4'hf;
   usfc_pkg::usfc_line_cfg_t lineCfg;
   logic [4:0] regAddr = 5'h00;
   logic [7:0] regWrData = 8'h00, regRdData, rxFifoData, flowReqChar, lastChar, takeCount;
   logic [7:0] rdVal, st, wrData = 8'h00;
   logic [6:0] rxLevel = 7'h00;
   usfc_pkg::usfc_rx_char_t rxChar = '0;
   logic rxFifoWr, flowReqValid, flowReqTake, txHalt, pauseIrq;
   logic serialOut, rtsN, dtrN, rxDmaReadyN, txDmaReadyN;
   int bad_count = 0, total_checks = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (rxFifoWr) wrData <= rxFifoData;
   usfc_top usfc_top_i (.ref_clk(ref_clk), .srst(srst), .ce(ce), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .rxChar(rxChar), .rxLevel(rxLevel), .rxFifoWr(rxFifoWr), .rxFifoData(rxFifoData),
      .flowReqValid(flowReqValid), .flowReqChar(flowReqChar), .flowReqTake(flowReqTake),
      .txHalt(txHalt), .pauseIrq(pauseIrq), .txSerial(1'b0), .serialOut(serialOut),
      .txFifoEmpty(1'b1), .txShiftEmpty(1'b1), .txFifoFull(1'b0), .rxDataReady(1'b0),
      .modemPinsN(pinsN), .rtsN(rtsN), .dtrN(dtrN), .rxDmaReadyN(rxDmaReadyN),
      .txDmaReadyN(txDmaReadyN), .lineCfg(lineCfg));
   usfc_remote_tx usfc_remote_tx_i (.ref_clk(ref_clk), .srst(srst), .slow(slow),
      .flowReqValid(flowReqValid), .flowReqChar(flowReqChar), .flowReqTake(flowReqTake),
      .lastChar(lastChar), .takeCount(takeCount));
   task automatic test_done;
      if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdChk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 rdVal = regRdData;
      chk(rdVal & m, e);
      @(posedge ref_clk);
   endtask
   // Characters stay three cycles apart; st holds {pauseIrq, txHalt} once both settled.
   task automatic rx(input logic [7:0] d, input logic e);
      rxChar <= '{1'b1, e, d};
      @(posedge ref_clk);
      rxChar.valid <= 1'b0;
      @(posedge ref_clk);
      #1 st = {6'h00, pauseIrq, txHalt};
      @(posedge ref_clk);
   endtask
   task automatic waitTake(input logic [7:0] n, input logic [7:0] c);
      for (int i = 0; i < 100 && takeCount < n; i++) @(posedge ref_clk);
      #1 chk(takeCount, n);
      chk(lastChar, c);
      @(posedge ref_clk);
   endtask
   initial begin
      #200000;
      bad_count++;
      test_done;
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 chk({3'h0, serialOut, rtsN, dtrN, rxDmaReadyN, txDmaReadyN}, 8'h1e);
      chk(lineCfg.line_control_reg, 8'h1d);
      @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      rdChk(usfc_pkg::ADDR_IIR_FCR, 8'hff, 8'h01);
      rdChk(usfc_pkg::ADDR_EFR, 8'hff, 8'h00);
      rdChk(usfc_pkg::ADDR_TCR, 8'hff, 8'h00);
      rdChk(usfc_pkg::ADDR_LCR, 8'hff, 8'h1d);
      rdChk(usfc_pkg::ADDR_LSR, 8'hff, 8'h60);
      rdChk(usfc_pkg::ADDR_MSR, 8'h0f, 8'h00);
      rdChk(usfc_pkg::ADDR_AFR, 8'hff, 8'h10);
      wr(usfc_pkg::ADDR_SPR, 8'h5a);
      wr(usfc_pkg::ADDR_PAU1, 8'h0f);
      wr(usfc_pkg::ADDR_RES1, 8'h0d);
      wr(usfc_pkg::ADDR_PAU2, 8'h13);
      wr(usfc_pkg::ADDR_IER, 8'h20);
      // Hardware flow bits 7:6 stay clear whenever software flow is on.
      wr(usfc_pkg::ADDR_EFR, 8'h02);
      rx(8'h0f, 1'b1);
      chk({wrData[7:1], st[0]}, 8'h0e);
      rx(8'h0f, 1'b0);
      chk(st, 8'h03);
      rdChk(usfc_pkg::ADDR_IIR_FCR, 8'h10, 8'h10);
      rx(8'h0d, 1'b0);
      chk(st, 8'h00);
      wr(usfc_pkg::ADDR_MCR, 8'h20);
      rx(8'h0f, 1'b0);
      rx(8'h41, 1'b0);
      chk(st, 8'h00);
      wr(usfc_pkg::ADDR_MCR, 8'h00);
      wr(usfc_pkg::ADDR_EFR, 8'h22);
      rx(8'h13, 1'b0);
      chk({wrData[7:1], st[0]}, 8'h12);
      rdChk(usfc_pkg::ADDR_IIR_FCR, 8'h10, 8'h10);
      rdChk(usfc_pkg::ADDR_IIR_FCR, 8'h10, 8'h00);
      wr(usfc_pkg::ADDR_TCR, 8'h12);
      wr(usfc_pkg::ADDR_EFR, 8'h08);
      rxLevel <= 7'h08;
      repeat (4) @(posedge ref_clk);
      chk(takeCount, 8'h00);
      rxLevel <= 7'h09;
      waitTake(8'h01, 8'h0f);
      slow <= 1'b1;
      rxLevel <= 7'h04;
      waitTake(8'h02, 8'h0d);
      rxLevel <= 7'h09;
      waitTake(8'h03, 8'h0f);
      wr(usfc_pkg::ADDR_EFR, 8'h00);
      waitTake(8'h04, 8'h0d);
      srst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      // A write while the clock enable is low must be lost.
      ce <= 1'b0;
      wr(usfc_pkg::ADDR_SPR, 8'ha5);
      ce <= 1'b1;
      rdChk(usfc_pkg::ADDR_SPR, 8'hff, 8'h5a);
      rdChk(usfc_pkg::ADDR_IER, 8'hff, 8'h00);
      // Pair mode holds a first character and writes it once the pair is broken.
      wr(usfc_pkg::ADDR_EFR, 8'h03);
      rx(8'h0f, 1'b0);
      chk(wrData, 8'h13);
      rx(8'h0d, 1'b0);
      chk(wrData, 8'h0f);
      pinsN <= 4'h7;
      @(posedge ref_clk);
      rdChk(usfc_pkg::ADDR_MSR, 8'hff, 8'h88);
      rdChk(usfc_pkg::ADDR_MSR, 8'hff, 8'h80);
      test_done;
   end
endmodule
`default_nettype wire

/* bench/usfc_remote_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module usfc_remote_tx (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic slow,
   input wire logic flowReqValid,
   input wire logic [7:0] flowReqChar,
   output logic flowReqTake,
   output logic [7:0] lastChar,
   output logic [7:0] takeCount
);
   logic [2:0] wait_r;
   // A slow transmitter leaves the request pending, so the sender must hold it.
   always_ff @(posedge ref_clk) begin
      flowReqTake <= 1'b0;
      if (srst) begin
         wait_r <= 3'h0;
         takeCount <= 8'h00;
      end else if (flowReqValid && !flowReqTake) begin
         if (wait_r >= (slow ? 3'h5 : 3'h0)) begin
            flowReqTake <= 1'b1;
            lastChar <= flowReqChar;
            takeCount <= takeCount + 8'h01;
            wait_r <= 3'h0;
         end else begin
            wait_r <= wait_r + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* hw/usfc_pkg.sv */
`default_nettype none
package usfc_pkg;
   // Register byte addresses on the plain register port.
   localparam logic [4:0] ADDR_IER = 5'h00;
   localparam logic [4:0] ADDR_IIR_FCR = 5'h01;
   localparam logic [4:0] ADDR_LCR = 5'h02;
   localparam logic [4:0] ADDR_MCR = 5'h03;
   localparam logic [4:0] ADDR_LSR = 5'h04;
   localparam logic [4:0] ADDR_MSR = 5'h05;
   localparam logic [4:0] ADDR_SPR = 5'h06;
   localparam logic [4:0] ADDR_EFR = 5'h07;
   localparam logic [4:0] ADDR_TCR = 5'h08;
   localparam logic [4:0] ADDR_TLR = 5'h09;
   localparam logic [4:0] ADDR_AFR = 5'h0a;
   localparam logic [4:0] ADDR_DLL = 5'h0b;
   localparam logic [4:0] ADDR_DLH = 5'h0c;
   localparam logic [4:0] ADDR_RES1 = 5'h0d;
   localparam logic [4:0] ADDR_RES2 = 5'h0e;
   localparam logic [4:0] ADDR_PAU1 = 5'h0f;
   localparam logic [4:0] ADDR_PAU2 = 5'h10;

   // Values after reset.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_LCR = 8'h1d;
   localparam logic [7:0] RST_LSR = 8'h60;
   localparam logic [7:0] RST_AFR = 8'h10;
   localparam logic [3:0] RST_PINS = 4'hf;

   // Field positions.
   localparam int IIR_PAUSE_BIT = 4;
   localparam int IIR_NONE_BIT = 0;
   localparam int EFR_SPECIAL_BIT = 5;
   localparam int MCR_ANY_RESUME_BIT = 5;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_DTR_BIT = 0;
   localparam int IER_PAUSE_BIT = 5;
   localparam int FCR_ENABLE_BIT = 0;
   // Threshold fields count in steps of four characters.
   localparam int LEVEL_STEP_SHIFT = 2;

   // Flow character selection codes of the enhanced feature field.
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_SECOND = 2'h1;
   localparam logic [1:0] MODE_FIRST = 2'h2;
   localparam logic [1:0] MODE_BOTH = 2'h3;

   typedef struct packed {
      logic valid;
      logic err;
      logic [7:0] data;
   } usfc_rx_char_t;

   typedef struct packed {
      logic [7:0] line_control_reg;
      logic [7:0] fifo_control_reg;
      logic [7:0] fifo_trigger_reg;
      logic [7:0] alternate_function_reg;
      logic [7:0] modem_control_reg;
      logic [15:0] divisor;
   } usfc_line_cfg_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'h1,
      RX_HELD_PAUSE = 3'h2,
      RX_HELD_RESUME = 3'h4
   } usfc_rx_state_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h1,
      TX_SEND_A = 3'h2,
      TX_SEND_B = 3'h4
   } usfc_tx_state_t;
endpackage
`default_nettype wire

/* hw/usfc_top.sv */
// Function
// - Enhanced feature bits 3:2 choose which pause/resume characters are transmitted.
// - Enhanced feature bits 1:0 choose which received characters are compared.
// - Receive 11 with transmit 10 or 01 accepts either pause or resume character.
// - With modem control bit 5 set, any character but a matching pause resumes a paused transmitter.
// - Special character equal to second pause sets flag and interrupt but does not halt; stored; INTERRUPT_IDENT_REG read clears.
// - Matching pause halts transmitter after current character, sets flag and interrupt.
// - Matching resume clears the flag, drops the interrupt and resumes transmission.
// - A received character with error is plain data, never a flow character.
// - Send pause characters once the receive level passes the halt threshold.
// - Send resume characters when the receive level reaches the resume threshold.
// - Disabling flow control after a pause was sent sends resume characters.
// - Mode change after pause sends old resume, then new pause if still full.
// - Flow characters are framed as data, cut to the programmed word length.
// - In pair mode an unmatched first character is written to the receive FIFO.
// - Reset sets INTERRUPT_IDENT_REG to bit 0 only and clears INTERRUPT_ENABLE_REG, FIFO_CONTROL_REG, MODEM_CONTROL_REG, ENHANCED_FEATURE_REG, FLOW_THRESHOLD_REG, FIFO_TRIGGER_REG.
// - Reset loads the line control register with 1D hex.
// - Reset leaves the line status register with only bits 5 and 6 set.
// - Reset clears modem status bits 3:0; bits 7:4 follow the modem pins.
// - Reset leaves the alternate function register with only bit 4 set.
// - Reset keeps divisor, scratch and the four flow character registers.
// - In reset serial out, RTS, DTR, RX-ready are high; TX-ready is low.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module usfc_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire usfc_pkg::usfc_rx_char_t rxChar,
   input wire logic [6:0] rxLevel,
   output logic rxFifoWr,
   output logic [7:0] rxFifoData,
   output logic flowReqValid,
   output logic [7:0] flowReqChar,
   input wire logic flowReqTake,
   output logic txHalt,
   output logic pauseIrq,
   input wire logic txSerial,
   output logic serialOut,
   input wire logic txFifoEmpty,
   input wire logic txShiftEmpty,
   input wire logic txFifoFull,
   input wire logic rxDataReady,
   input wire logic [3:0] modemPinsN,
   output logic rtsN,
   output logic dtrN,
   output logic rxDmaReadyN,
   output logic txDmaReadyN,
   output var usfc_pkg::usfc_line_cfg_t lineCfg
);
   logic [7:0] ier_r, fcr_r, lcr_r, mcr_r, efr_r, tcr_r, tlr_r, afr_r, lsr_r;
   logic [7:0] dll_r, dlh_r, spr_r, resumeFirst_r, resumeSecond_r, pauseFirst_r, pauseSecond_r;
   logic [3:0] msrDelta_r, pinsPrev_r;
   logic flag_r, bySpecial_r, halt_r, irq_r;
   logic [7:0] rdData_r, rdNxt;
   logic fifoWr_r, spillValid_r;
   logic [7:0] fifoData_r, spillData_r, heldChar_r;
   logic serial_r, rts_r, dtr_r, rx_dma_ready_r, tx_dma_ready_r;
   usfc_pkg::usfc_rx_state_t rxState_r;
   usfc_pkg::usfc_tx_state_t txState_r;
   logic flowReq_r, sendPause_r, pauseSent_r;
   logic [7:0] flowChar_r;
   logic [1:0] sendMode_r, sentMode_r;

   function automatic logic [7:0] wlMask(input logic [1:0] wl);
      case (wl)
         2'h0: return 8'h1f;
         2'h1: return 8'h3f;
         2'h2: return 8'h7f;
         default: return 8'hff;
      endcase
   endfunction

   function automatic logic [7:0] pickChar(input logic [1:0] mode, input logic second,
                                           input logic [7:0] c1, input logic [7:0] c2);
      if (mode == usfc_pkg::MODE_BOTH) begin
         return second ? c2 : c1;
      end
      return (mode == usfc_pkg::MODE_FIRST) ? c1 : c2;
   endfunction

   // Register port decode.
   wire wrIer = regWr && regAddr == usfc_pkg::ADDR_IER;
   wire wrFcr = regWr && regAddr == usfc_pkg::ADDR_IIR_FCR;
   wire wrLcr = regWr && regAddr == usfc_pkg::ADDR_LCR;
   wire wrMcr = regWr && regAddr == usfc_pkg::ADDR_MCR;
   wire wrSpr = regWr && regAddr == usfc_pkg::ADDR_SPR;
   wire wrEfr = regWr && regAddr == usfc_pkg::ADDR_EFR;
   wire wrTcr = regWr && regAddr == usfc_pkg::ADDR_TCR;
   wire wrTlr = regWr && regAddr == usfc_pkg::ADDR_TLR;
   wire wrAfr = regWr && regAddr == usfc_pkg::ADDR_AFR;
   wire wrDll = regWr && regAddr == usfc_pkg::ADDR_DLL;
   wire wrDlh = regWr && regAddr == usfc_pkg::ADDR_DLH;
   wire wrRes1 = regWr && regAddr == usfc_pkg::ADDR_RES1;
   wire wrRes2 = regWr && regAddr == usfc_pkg::ADDR_RES2;
   wire wrPau1 = regWr && regAddr == usfc_pkg::ADDR_PAU1;
   wire wrPau2 = regWr && regAddr == usfc_pkg::ADDR_PAU2;
   wire rdIir = regRd && regAddr == usfc_pkg::ADDR_IIR_FCR;
   wire rdMsr = regRd && regAddr == usfc_pkg::ADDR_MSR;
   wire [7:0] iirValue = {fcr_r[usfc_pkg::FCR_ENABLE_BIT], fcr_r[usfc_pkg::FCR_ENABLE_BIT],
                          1'b0, flag_r, 3'h0, ~flag_r};

   // Receive side comparison.
   wire [7:0] wm = wlMask(lcr_r[1:0]);
   wire [7:0] cur = rxChar.data & wm;
   wire isP1 = cur == (pauseFirst_r & wm);
   wire isP2 = cur == (pauseSecond_r & wm);
   wire isR1 = cur == (resumeFirst_r & wm);
   wire isR2 = cur == (resumeSecond_r & wm);
   wire [1:0] rxm = efr_r[1:0];
   wire [1:0] txm = efr_r[3:2];
   wire rxGo = ce && rxChar.valid;
   wire flowOk = rxGo && !rxChar.err;
   wire seqMode = rxm == usfc_pkg::MODE_BOTH &&
                  (txm == usfc_pkg::MODE_BOTH || txm == usfc_pkg::MODE_NONE);
   wire eitherMode = rxm == usfc_pkg::MODE_BOTH && !seqMode;
   wire singleP = (rxm == usfc_pkg::MODE_FIRST && isP1) ||
                  (rxm == usfc_pkg::MODE_SECOND && isP2) || (eitherMode && (isP1 || isP2));
   wire singleR = (rxm == usfc_pkg::MODE_FIRST && isR1) ||
                  (rxm == usfc_pkg::MODE_SECOND && isR2) || (eitherMode && (isR1 || isR2));
   wire heldP = rxState_r == usfc_pkg::RX_HELD_PAUSE;
   wire heldR = rxState_r == usfc_pkg::RX_HELD_RESUME;
   wire seqP = seqMode && heldP && isP2;
   wire seqR = seqMode && heldR && isR2;
   wire pauseAct = flowOk && (singleP || seqP);
   wire resumeAct = flowOk && (singleR || seqR) && !pauseAct;
   wire holdP = flowOk && seqMode && isP1 && !seqP && !seqR;
   wire holdR = flowOk && seqMode && isR1 && !seqP && !seqR && !holdP;
   wire specialHit = flowOk && efr_r[usfc_pkg::EFR_SPECIAL_BIT] && isP2 && !pauseAct;
   wire anyResume = rxGo && mcr_r[usfc_pkg::MCR_ANY_RESUME_BIT] && halt_r && !pauseAct;
   wire consumed = pauseAct || resumeAct || holdP || holdR;
   wire flush = rxGo && (heldP || heldR) && !seqP && !seqR;
   wire writeCur = rxGo && !consumed;
   wire wrNow = spillValid_r || flush || writeCur;
   wire [7:0] dataNow = spillValid_r ? spillData_r : (flush ? heldChar_r : rxChar.data);
   wire spillNxt = flush && writeCur && !spillValid_r;

   // Transmit side thresholds.
   wire [6:0] haltLvl = {1'b0, tcr_r[3:0], 2'h0};
   wire [6:0] resumeLvl = {1'b0, tcr_r[7:4], 2'h0};
   // Hardware flow control is assumed off whenever these characters are used.
   wire needResume = pauseSent_r && (txm != sentMode_r || rxLevel <= resumeLvl);
   wire needPause = !pauseSent_r && txm != usfc_pkg::MODE_NONE && rxLevel > haltLvl;
   wire startSend = txState_r == usfc_pkg::TX_IDLE && (needResume || needPause);
   wire [1:0] newMode = needResume ? sentMode_r : txm;
   wire [7:0] firstChar = needResume ?
                          pickChar(newMode, 1'b0, resumeFirst_r, resumeSecond_r) :
                          pickChar(newMode, 1'b0, pauseFirst_r, pauseSecond_r);
   wire [7:0] secondChar = sendPause_r ? pauseSecond_r : resumeSecond_r;

   always_comb begin
      case (regAddr)
         usfc_pkg::ADDR_IER: rdNxt = ier_r;
         usfc_pkg::ADDR_IIR_FCR: rdNxt = iirValue;
         usfc_pkg::ADDR_LCR: rdNxt = lcr_r;
         usfc_pkg::ADDR_MCR: rdNxt = mcr_r;
         usfc_pkg::ADDR_LSR: rdNxt = lsr_r;
         usfc_pkg::ADDR_MSR: rdNxt = {~modemPinsN, msrDelta_r};
         usfc_pkg::ADDR_SPR: rdNxt = spr_r;
         usfc_pkg::ADDR_EFR: rdNxt = efr_r;
         usfc_pkg::ADDR_TCR: rdNxt = tcr_r;
         usfc_pkg::ADDR_TLR: rdNxt = tlr_r;
         usfc_pkg::ADDR_AFR: rdNxt = afr_r;
         usfc_pkg::ADDR_DLL: rdNxt = dll_r;
         usfc_pkg::ADDR_DLH: rdNxt = dlh_r;
         usfc_pkg::ADDR_RES1: rdNxt = resumeFirst_r;
         usfc_pkg::ADDR_RES2: rdNxt = resumeSecond_r;
         usfc_pkg::ADDR_PAU1: rdNxt = pauseFirst_r;
         usfc_pkg::ADDR_PAU2: rdNxt = pauseSecond_r;
         default: rdNxt = usfc_pkg::RST_ZERO;
      endcase
   end

   // Reset-controlled control registers.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ier_r <= usfc_pkg::RST_ZERO;
         fcr_r <= usfc_pkg::RST_ZERO;
         mcr_r <= usfc_pkg::RST_ZERO;
         efr_r <= usfc_pkg::RST_ZERO;
         tcr_r <= usfc_pkg::RST_ZERO;
         tlr_r <= usfc_pkg::RST_ZERO;
         lcr_r <= usfc_pkg::RST_LCR;
         afr_r <= usfc_pkg::RST_AFR;
      end else if (ce) begin
         if (wrIer) ier_r <= regWrData;
         if (wrFcr) fcr_r <= regWrData;
         if (wrMcr) mcr_r <= regWrData;
         if (wrEfr) efr_r <= regWrData;
         if (wrTcr) tcr_r <= regWrData;
         if (wrTlr) tlr_r <= regWrData;
         if (wrLcr) lcr_r <= regWrData;
         if (wrAfr) afr_r <= regWrData;
      end
   end

   // These registers have no reset on purpose, so a reset keeps the programmed baud and characters.
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         if (wrDll) dll_r <= regWrData;
         if (wrDlh) dlh_r <= regWrData;
         if (wrSpr) spr_r <= regWrData;
         if (wrRes1) resumeFirst_r <= regWrData;
         if (wrRes2) resumeSecond_r <= regWrData;
         if (wrPau1) pauseFirst_r <= regWrData;
         if (wrPau2) pauseSecond_r <= regWrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdData_r <= usfc_pkg::RST_ZERO;
         lsr_r <= usfc_pkg::RST_LSR;
         msrDelta_r <= 4'h0;
         pinsPrev_r <= usfc_pkg::RST_PINS;
      end else if (ce) begin
         rdData_r <= regRd ? rdNxt : usfc_pkg::RST_ZERO;
         lsr_r <= {1'b0, txShiftEmpty && txFifoEmpty, txFifoEmpty, 4'h0, rxDataReady};
         pinsPrev_r <= modemPinsN;
         // A pin change in the read cycle is kept: the set wins.
         msrDelta_r <= (rdMsr ? 4'h0 : msrDelta_r) | (pinsPrev_r ^ modemPinsN);
      end
   end

   // Pause flag, halt and interrupt.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flag_r <= 1'b0;
         bySpecial_r <= 1'b0;
         halt_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (ce) begin
         if (pauseAct || specialHit) begin
            flag_r <= 1'b1;
         end else if (resumeAct || anyResume || (rdIir && bySpecial_r)) begin
            flag_r <= 1'b0;
         end
         if (specialHit) begin
            bySpecial_r <= 1'b1;
         end else if (pauseAct || !flag_r) begin
            bySpecial_r <= 1'b0;
         end
         if (pauseAct) begin
            halt_r <= 1'b1;
         end else if (resumeAct || anyResume) begin
            halt_r <= 1'b0;
         end
         irq_r <= flag_r && ier_r[usfc_pkg::IER_PAUSE_BIT];
      end
   end

   // Receive FIFO write path; a flushed held character can leave one character to spill.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fifoWr_r <= 1'b0;
         fifoData_r <= usfc_pkg::RST_ZERO;
         spillValid_r <= 1'b0;
         spillData_r <= usfc_pkg::RST_ZERO;
         heldChar_r <= usfc_pkg::RST_ZERO;
         rxState_r <= usfc_pkg::RX_IDLE;
      end else if (ce) begin
         fifoWr_r <= wrNow;
         fifoData_r <= dataNow;
         spillValid_r <= spillNxt;
         if (spillNxt) spillData_r <= rxChar.data;
         if (holdP || holdR) heldChar_r <= rxChar.data;
         case (rxState_r)
            usfc_pkg::RX_IDLE, usfc_pkg::RX_HELD_PAUSE, usfc_pkg::RX_HELD_RESUME: begin
               if (holdP) begin
                  rxState_r <= usfc_pkg::RX_HELD_PAUSE;
               end else if (holdR) begin
                  rxState_r <= usfc_pkg::RX_HELD_RESUME;
               end else if (rxChar.valid) begin
                  rxState_r <= usfc_pkg::RX_IDLE;
               end
            end
            default: rxState_r <= usfc_pkg::RX_IDLE;
         endcase
      end
   end

   // Flow character sender; the transmitter frames each character like FIFO data.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         txState_r <= usfc_pkg::TX_IDLE;
         flowReq_r <= 1'b0;
         flowChar_r <= usfc_pkg::RST_ZERO;
         sendMode_r <= usfc_pkg::MODE_NONE;
         sendPause_r <= 1'b0;
         pauseSent_r <= 1'b0;
         sentMode_r <= usfc_pkg::MODE_NONE;
      end else if (ce) begin
         case (txState_r)
            usfc_pkg::TX_IDLE: begin
               if (startSend) begin
                  flowReq_r <= 1'b1;
                  flowChar_r <= firstChar & wm;
                  sendMode_r <= newMode;
                  sendPause_r <= !needResume;
                  pauseSent_r <= !needResume;
                  if (!needResume) sentMode_r <= txm;
                  txState_r <= usfc_pkg::TX_SEND_A;
               end
            end
            usfc_pkg::TX_SEND_A: begin
               if (flowReqTake) begin
                  if (sendMode_r == usfc_pkg::MODE_BOTH) begin
                     flowChar_r <= secondChar & wm;
                     txState_r <= usfc_pkg::TX_SEND_B;
                  end else begin
                     flowReq_r <= 1'b0;
                     txState_r <= usfc_pkg::TX_IDLE;
                  end
               end
            end
            usfc_pkg::TX_SEND_B: begin
               if (flowReqTake) begin
                  flowReq_r <= 1'b0;
                  txState_r <= usfc_pkg::TX_IDLE;
               end
            end
            default: begin
               flowReq_r <= 1'b0;
               txState_r <= usfc_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // Pin outputs; reset forces the idle levels regardless of the clock enable.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         serial_r <= 1'b1;
         rts_r <= 1'b1;
         dtr_r <= 1'b1;
         rx_dma_ready_r <= 1'b1;
         tx_dma_ready_r <= 1'b0;
      end else if (ce) begin
         serial_r <= txSerial;
         rts_r <= !mcr_r[usfc_pkg::MCR_RTS_BIT];
         dtr_r <= !mcr_r[usfc_pkg::MCR_DTR_BIT];
         rx_dma_ready_r <= rxLevel == 7'h00;
         tx_dma_ready_r <= txFifoFull;
      end
   end

   assign regRdData = rdData_r;
   assign rxFifoWr = fifoWr_r;
   assign rxFifoData = fifoData_r;
   assign flowReqValid = flowReq_r;
   assign flowReqChar = flowChar_r;
   assign txHalt = halt_r;
   assign pauseIrq = irq_r;
   assign serialOut = serial_r;
   assign rtsN = rts_r;
   assign dtrN = dtr_r;
   assign rxDmaReadyN = rx_dma_ready_r;
   assign txDmaReadyN = tx_dma_ready_r;
   assign lineCfg = {lcr_r, fcr_r, tlr_r, afr_r, mcr_r, dlh_r, dll_r};

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_pause_halts;
      (pauseAct) |=> txHalt;
   endproperty
   a_pause_halts: assert property (p_pause_halts) else $error("pause did not halt");

   property p_irq_follows;
      (pauseAct && ier_r[usfc_pkg::IER_PAUSE_BIT]) ##1 ce |=> pauseIrq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("pause irq missing");

   property p_resume_clears;
      (resumeAct) |=> !txHalt && !flag_r;
   endproperty
   a_resume_clears: assert property (p_resume_clears) else $error("resume failed");

   property p_err_is_data;
      (ce && rxChar.valid && rxChar.err && !spillValid_r && rxState_r == usfc_pkg::RX_IDLE)
         |=> rxFifoWr && rxFifoData == $past(rxChar.data);
   endproperty
   a_err_is_data: assert property (p_err_is_data) else $error("error char not stored");

   property p_pause_sent;
      (ce && txState_r == usfc_pkg::TX_IDLE && needPause && !needResume)
         |=> flowReqValid && pauseSent_r;
   endproperty
   a_pause_sent: assert property (p_pause_sent) else $error("pause not sent");

   property p_resume_sent;
      (ce && txState_r == usfc_pkg::TX_IDLE && needResume) |=> flowReqValid && !pauseSent_r;
   endproperty
   a_resume_sent: assert property (p_resume_sent) else $error("resume not sent");

   property p_char_masked;
      flowReqValid |-> (flowReqChar & ~wm) == 8'h00 || $changed(lcr_r);
   endproperty
   a_char_masked: assert property (p_char_masked) else $error("flow char not masked");

   property p_special;
      (specialHit && !spillValid_r) |=> flag_r && rxFifoWr && $stable(txHalt);
   endproperty
   a_special: assert property (p_special) else $error("special char wrong");

   property p_seq_flush;
      (ce && heldP && rxChar.valid && !isP2 && !spillValid_r)
         |=> rxFifoWr && rxFifoData == $past(heldChar_r);
   endproperty
   a_seq_flush: assert property (p_seq_flush) else $error("held char lost");

   property p_reset_regs;
      disable iff (1'b0) $past(srst) |-> lineCfg.line_control_reg == usfc_pkg::RST_LCR &&
         lineCfg.alternate_function_reg == usfc_pkg::RST_AFR && !flag_r && ier_r == usfc_pkg::RST_ZERO;
   endproperty
   a_reset_regs: assert property (p_reset_regs) else $error("reset values wrong");

   property p_reset_pins;
      disable iff (1'b0) $past(srst) |-> serialOut && rtsN && dtrN && rxDmaReadyN && !txDmaReadyN;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("reset pin levels wrong");

   c_pause: cover property (pauseAct ##[1:50] resumeAct);
   c_both_send: cover property (txState_r == usfc_pkg::TX_SEND_B && flowReqTake);
   c_special: cover property (specialHit);
   c_mode_change: cover property (pauseSent_r && txm != sentMode_r);
endmodule
`default_nettype wire
